// >>> verilog/pvs_regs.sv
// vendor management registers behind the management serial interface
`timescale 1ns/1ps
`include "pvs_consts.svh"

module pvs_regs (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// management serial pins
	input  wire logic        mdc,
	input  wire logic        mdioIn,
	output logic             mdioOut,
	output logic             mdioOe,
	// interrupt pin
	output logic             mgmt_irq_n,
	// strap pins sampled at reset release
	input  wire logic [13:0] strapPins,
	// status from the transceiver core, same clock
	input  wire logic        linkUp,
	input  wire logic        speed100,
	input  wire logic        fullDuplex,
	input  wire logic        loopback10,
	input  wire logic        polarity_reversed,
	input  wire logic        rx_error_event,
	input  wire logic        disconnectEvent,
	// effective controls to the 10M datapath
	output logic             link_pulse_enable,
	output logic             linkGoodForced,
	output logic             heartbeat_enable,
	output logic             squelchNormal,
	output logic             jabber_enable,
	output logic             serial_7wire_select
);

	//------------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------------
	logic        mdcS1_q, mdcS2_q, mdcS3_q;
	logic        mdioS1_q, mdioS2_q;
	logic [13:0] strapS1_q, strapS2_q;
	logic        mdcRise;

	// two flops per pin; third mdc flop only finds the edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mdcS1_q   <= 1'b0;
			mdcS2_q   <= 1'b0;
			mdcS3_q   <= 1'b0;
			mdioS1_q  <= 1'b1;
			mdioS2_q  <= 1'b1;
			strapS1_q <= 14'h0;
			strapS2_q <= 14'h0;
		end else begin
			mdcS1_q   <= mdc;
			mdcS2_q   <= mdcS1_q;
			mdcS3_q   <= mdcS2_q;
			mdioS1_q  <= mdioIn;
			mdioS2_q  <= mdioS1_q;
			strapS1_q <= strapPins;
			strapS2_q <= strapS1_q;
		end
	end

	assign mdcRise = mdcS2_q & ~mdcS3_q;

	//------------------------------------------------------------------
	// strap capture
	//------------------------------------------------------------------
	logic [1:0]  strapWait_q;
	logic [13:0] strap_q;
	logic        strapTake;

	// waits for the synchronisers to fill before the single capture
	assign strapTake = (strapWait_q == `PVS_STRAP_WAIT - 2'h1);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			strapWait_q <= 2'h0;
			strap_q     <= 14'h0;
		end else begin
			if (strapWait_q != `PVS_STRAP_WAIT)
				strapWait_q <= strapWait_q + 2'h1;
			if (strapTake)
				strap_q <= strapS2_q;
		end
	end

	//------------------------------------------------------------------
	// 10 Mbps configuration register
	//------------------------------------------------------------------
	logic [4:0] tenCfg_q;     // {pulse, heartbeat, squelch, jabber, serial}
	logic [4:0] tenCfg_d;
	logic       wrTen;
	logic       wrIrq;
	logic       rdIrqDone;
	pvs_pkg::pvs_word_t wrData;

	// only the five defined bits are stored
	assign tenCfg_d = wrData[`PVS_B_LPEN:`PVS_B_SER];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			tenCfg_q <= `PVS_TENBASE_RST;
		else if (wrTen)
			tenCfg_q <= tenCfg_d;
	end

	//------------------------------------------------------------------
	// interrupt masks and change unit
	//------------------------------------------------------------------
	logic [3:0] imask_q;
	pvs_irq_if  irqBus ();

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			imask_q <= `PVS_IMASK_RST;
		else if (wrIrq)
			imask_q <= wrData[`PVS_B_MDPX:`PVS_B_MMASTER];
	end

	assign irqBus.linkUp     = linkUp;
	assign irqBus.speed100   = speed100;
	assign irqBus.fullDuplex = fullDuplex;
	assign irqBus.readClr    = rdIrqDone;
	assign irqBus.masks      = imask_q;

	pvs_change_irq u_chg (
		.clk    (clk),
		.resetn (resetn),
		.irq    (irqBus.unit)
	);

	//------------------------------------------------------------------
	// event counters
	//------------------------------------------------------------------
	logic [15:0] rxErr_q;
	logic [7:0]  disc_q;

	// count and wrap, reads leave them
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxErr_q <= 16'h0;
			disc_q  <= 8'h0;
		end else begin
			if (rx_error_event)
				rxErr_q <= rxErr_q + 16'h1;
			if (disconnectEvent)
				disc_q <= disc_q + 8'h1;
		end
	end

	//------------------------------------------------------------------
	// read data selection
	//------------------------------------------------------------------
	logic [4:0]         regAddr;
	pvs_pkg::pvs_word_t tenWord;
	pvs_pkg::pvs_word_t irqWord;
	pvs_pkg::pvs_word_t rdWord;
	logic               istat;

	// polarity flag straight from the receive logic
	// reserved bits of the word tied to zero
	assign tenWord = {1'b0, tenCfg_q, 9'h0, polarity_reversed};
	assign istat   = irqBus.irqStatus;
	// pending mirrors status in bit zero
	assign irqWord = {istat, 3'h0, imask_q, 3'h0,
		irqBus.changes, 1'b0, istat};

	assign rdWord =
		(regAddr == `PVS_OFS_TENBASE) ? tenWord :
		(regAddr == `PVS_OFS_IRQ)     ? irqWord :
		(regAddr == `PVS_OFS_RXERR)   ? rxErr_q :
		(regAddr == `PVS_OFS_DISC)    ? {8'h0, disc_q} :
		(regAddr == `PVS_OFS_STRAP)   ? {2'h0, strap_q} :
		16'h0;

	//------------------------------------------------------------------
	// management frame engine
	//------------------------------------------------------------------
	pvs_pkg::pvs_state_t state_q;
	logic [5:0]  ones_q;
	logic [3:0]  bitCnt_q;
	logic [12:0] hdr_q;
	logic [15:0] shift_q;
	logic        taSecond_q;
	logic        mdioOut_q, mdioOe_q;
	logic        hdrLast, addrHit, isRead, isWrite, dataLast;
	logic [4:0]  phyAddr;
	logic [1:0]  opCode;
	logic [12:0] hdrNext;

	// device address comes from the low five strap bits
	assign phyAddr  = strap_q[4:0];
	assign hdrNext  = {hdr_q[11:0], mdioS2_q};
	assign hdrLast  = (bitCnt_q == `PVS_HDR_BITS - 4'h1);
	assign opCode   = hdrNext[11:10];
	assign addrHit  = hdrNext[12] & (hdrNext[9:5] == phyAddr);
	assign isRead   = addrHit & (opCode == `PVS_OP_READ);
	assign isWrite  = addrHit & (opCode == `PVS_OP_WRITE);
	assign regAddr  = hdr_q[4:0];
	assign dataLast = ({1'b0, bitCnt_q} == `PVS_DATA_BITS - 5'h1);
	assign wrData   = {shift_q[14:0], mdioS2_q};
	assign wrTen    = mdcRise & (state_q == pvs_pkg::ST_WR) & dataLast
		& (regAddr == `PVS_OFS_TENBASE);
	assign wrIrq    = mdcRise & (state_q == pvs_pkg::ST_WR) & dataLast
		& (regAddr == `PVS_OFS_IRQ);
	// clear on the cycle the word is taken
	assign rdIrqDone = mdcRise & (state_q == pvs_pkg::ST_TA)
		& taSecond_q & (hdr_q[11:10] == `PVS_OP_READ)
		& (regAddr == `PVS_OFS_IRQ);

	// consecutive ones form the preamble
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			ones_q <= 6'h0;
		else if (mdcRise) begin
			if (!mdioS2_q || state_q != pvs_pkg::ST_IDLE)
				ones_q <= 6'h0;
			else if (ones_q != `PVS_PREAMBLE)
				ones_q <= ones_q + 6'h1;
		end
	end

	// frame sequencing on each sampled mdc rising edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q    <= pvs_pkg::ST_IDLE;
			bitCnt_q   <= 4'h0;
			hdr_q      <= 13'h0;
			shift_q    <= 16'h0;
			taSecond_q <= 1'b0;
			mdioOut_q  <= 1'b1;
			mdioOe_q   <= 1'b0;
		end else if (mdcRise) begin
			case (state_q)
			pvs_pkg::ST_IDLE: begin
				mdioOe_q <= 1'b0;
				bitCnt_q <= 4'h0;
				// start pattern opens with a zero after the preamble
				if (ones_q == `PVS_PREAMBLE && !mdioS2_q)
					state_q <= pvs_pkg::ST_HDR;
			end
			pvs_pkg::ST_HDR: begin
				hdr_q    <= hdrNext;
				bitCnt_q <= bitCnt_q + 4'h1;
				if (hdrLast) begin
					taSecond_q <= 1'b0;
					state_q    <= (isRead || isWrite) ?
						pvs_pkg::ST_TA : pvs_pkg::ST_IDLE;
				end
			end
			pvs_pkg::ST_TA: begin
				taSecond_q <= 1'b1;
				bitCnt_q   <= 4'h0;
				if (taSecond_q) begin
					if (hdr_q[11:10] == `PVS_OP_READ) begin
						// snapshot taken as the first bit goes out
						shift_q   <= {rdWord[14:0], 1'b0};
						mdioOut_q <= rdWord[15];
						mdioOe_q  <= 1'b1;
						state_q   <= pvs_pkg::ST_RD;
					end else
						state_q <= pvs_pkg::ST_WR;
				end else if (hdr_q[11:10] == `PVS_OP_READ) begin
					// turnaround: drive zero in its second half
					mdioOut_q <= 1'b0;
					mdioOe_q  <= 1'b1;
				end
			end
			pvs_pkg::ST_RD: begin
				bitCnt_q  <= bitCnt_q + 4'h1;
				shift_q   <= {shift_q[14:0], 1'b0};
				mdioOut_q <= shift_q[15];
				if (dataLast) begin
					mdioOe_q  <= 1'b0;
					mdioOut_q <= 1'b1;
					state_q   <= pvs_pkg::ST_IDLE;
				end
			end
			pvs_pkg::ST_WR: begin
				bitCnt_q <= bitCnt_q + 4'h1;
				shift_q  <= wrData;
				if (dataLast)
					state_q <= pvs_pkg::ST_IDLE;
			end
			default: begin
				state_q  <= pvs_pkg::ST_IDLE;
				mdioOe_q <= 1'b0;
			end
			endcase
		end
	end

	//------------------------------------------------------------------
	// effective 10M controls and pin outputs
	//------------------------------------------------------------------
	logic tenMeg;
	logic jabMode;
	logic lpEn_q, lgf_q, hb_q, sq_q, jab_q, ser_q, irqN_q;

	assign tenMeg  = ~speed100;
	assign jabMode = tenMeg & (fullDuplex | loopback10);

	// all outputs registered so the pins see clean levels
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lpEn_q <= 1'b0;
			lgf_q  <= 1'b0;
			hb_q   <= 1'b0;
			sq_q   <= 1'b1;
			jab_q  <= 1'b1;
			ser_q  <= 1'b0;
			irqN_q <= 1'b1;
		end else begin
			// pulses only at 10M; off forces link good
			lpEn_q <= tenMeg & tenCfg_q[4];
			lgf_q  <= tenMeg & ~tenCfg_q[4];
			hb_q   <= tenMeg & tenCfg_q[3] & ~fullDuplex;
			sq_q   <= tenCfg_q[2];
			// jabber bit acts in its modes; else stays on
			jab_q  <= jabMode ? tenCfg_q[1] : 1'b1;
			ser_q  <= tenMeg & tenCfg_q[0];
			// pin low while status is one
			irqN_q <= ~istat;
		end
	end

	assign link_pulse_enable   = lpEn_q;
	assign linkGoodForced      = lgf_q;
	assign heartbeat_enable    = hb_q;
	assign squelchNormal       = sq_q;
	assign jabber_enable       = jab_q;
	assign serial_7wire_select = ser_q;
	assign mgmt_irq_n          = irqN_q;
	assign mdioOut             = mdioOut_q;
	assign mdioOe              = mdioOe_q;

endmodule

// >>> pkg/pvs_consts.svh
// register offsets, field positions, reset values and frame counts
`ifndef PVS_CONSTS_SVH
`define PVS_CONSTS_SVH

// register offsets on the management serial interface
`define PVS_OFS_TENBASE  5'h12
`define PVS_OFS_IRQ      5'h15
`define PVS_OFS_RXERR    5'h16
`define PVS_OFS_DISC     5'h17
`define PVS_OFS_STRAP    5'h18

// 10 Mbps configuration fields
`define PVS_B_LPEN       14
`define PVS_B_HEART      13
`define PVS_B_SQUELCH    12
`define PVS_B_JABBER     11
`define PVS_B_SER        10
`define PVS_B_POLARITY   0
`define PVS_TENBASE_RST  5'h1E

// interrupt register fields
`define PVS_B_PEND       15
`define PVS_B_MDPX       11
`define PVS_B_MMASTER    8
`define PVS_B_CHG_LO     2
`define PVS_B_ISTAT      0
`define PVS_IMASK_RST    4'hF

// strap capture
`define PVS_STRAP_W      14
`define PVS_STRAP_WAIT   2'h3

// frame structure
`define PVS_PREAMBLE     6'h20
`define PVS_HDR_BITS     4'hD
`define PVS_DATA_BITS    5'h10
`define PVS_OP_READ      2'h2
`define PVS_OP_WRITE     2'h1

`endif

// >>> pkg/pvs_pkg.sv
// types shared by the vendor register bank
package pvs_pkg;

	// management frame engine states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_HDR  = 5'h02,
		ST_TA   = 5'h04,
		ST_RD   = 5'h08,
		ST_WR   = 5'h10
	} pvs_state_t;

	typedef logic [15:0] pvs_word_t;

endpackage

// >>> pkg/pvs_irq_if.sv
// carrier between the register bank and its change/interrupt unit
`timescale 1ns/1ps
interface pvs_irq_if;
	logic       linkUp;
	logic       speed100;
	logic       fullDuplex;
	logic       readClr;
	logic [3:0] masks;     // {duplex, speed, link, master}
	logic [2:0] changes;   // {duplex, speed, link}
	logic       irqStatus;

	modport bank (output linkUp, speed100, fullDuplex, readClr, masks,
		input changes, irqStatus);
	modport unit (input linkUp, speed100, fullDuplex, readClr, masks,
		output changes, irqStatus);
endinterface

// >>> verilog/pvs_change_irq.sv
// latched link, speed and duplex change bits with interrupt gating
`timescale 1ns/1ps
module pvs_change_irq (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// bank side
	pvs_irq_if.unit   irq
);

	//------------------------------------------------------------------
	// previous state for edge finding
	//------------------------------------------------------------------
	logic [2:0] prev_q;
	logic [2:0] chg_q;
	logic [2:0] chg_d;
	logic [2:0] nowState;
	logic [2:0] events;
	logic [2:0] srcOpen;
	logic       primed_q;

	// status vector ordered like the change bits
	assign nowState = {irq.fullDuplex, irq.speed100, irq.linkUp};
	// first cycle after reset only loads prev: no false change from reset
	assign events   = primed_q ? (nowState ^ prev_q) : 3'h0;

	// latch on change
	// a change arriving with the read still sets: set beats clear
	assign chg_d = events | (irq.readClr ? 3'h0 : chg_q);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_q   <= 3'h0;
			chg_q    <= 3'h0;
			primed_q <= 1'b0;
		end else begin
			prev_q   <= nowState;
			chg_q    <= chg_d;
			primed_q <= 1'b1;
		end
	end

	assign srcOpen = chg_q & ~irq.masks[3:1];

	assign irq.irqStatus = ~irq.masks[0] & (|srcOpen);
	assign irq.changes   = chg_q;

endmodule

// >>> verification/pvs_regs_asserts.sv
// concurrent checks on the vendor register bank pins
`timescale 1ns/1ps
module pvs_regs_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// core status
	input wire logic speed100,
	input wire logic fullDuplex,
	input wire logic loopback10,
	// pins and controls
	input wire logic mdioOut,
	input wire logic mdioOe,
	input wire logic mgmt_irq_n,
	input wire logic link_pulse_enable,
	input wire logic linkGoodForced,
	input wire logic heartbeat_enable,
	input wire logic jabber_enable,
	input wire logic serial_7wire_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// cycles since reset, saturating; no write frame ends this soon
	logic [7:0] upCnt_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			upCnt_q <= 8'h00;
		else if (upCnt_q != 8'hFF)
			upCnt_q <= upCnt_q + 8'h01;
	end

	// read answer: turnaround zero, then the enable held for eight more cycles
	sequence taDrive;
		mdioOe && !mdioOut;
	endsequence
	sequence readHold;
		mdioOe [*8];
	endsequence

	lpen_pair_a: assert property (
		upCnt_q != 8'h00 && !$past(speed100)
		|-> link_pulse_enable ^ linkGoodForced) else $error("lpen pair");
	lpen_speed_a: assert property (
		$past(speed100) |-> !link_pulse_enable && !linkGoodForced)
		else $error("lpen at 100M");
	heartbeat_fdx_a: assert property (
		$past(fullDuplex) || $past(speed100) |-> !heartbeat_enable)
		else $error("heartbeat in fdx");
	jab_mode_a: assert property (
		!(!$past(speed100) && ($past(fullDuplex) || $past(loopback10)))
		|-> jabber_enable) else $error("jabber outside mode");
	ser_speed_a: assert property (
		$past(speed100) |-> !serial_7wire_select) else $error("serial 100M");
	mdio_idle_a: assert property (
		!mdioOe |-> mdioOut) else $error("mdio idle level");
	read_start_a: assert property (
		$rose(mdioOe) |-> taDrive ##1 readHold) else $error("read start");
	irq_quiet_a: assert property (
		upCnt_q != 8'hFF |-> mgmt_irq_n) else $error("irq after reset");
endmodule

bind pvs_regs pvs_regs_asserts chk (.clk(clk), .resetn(resetn),
	.speed100(speed100), .fullDuplex(fullDuplex), .loopback10(loopback10),
	.mdioOut(mdioOut), .mdioOe(mdioOe), .mgmt_irq_n(mgmt_irq_n),
	.link_pulse_enable(link_pulse_enable), .linkGoodForced(linkGoodForced),
	.heartbeat_enable(heartbeat_enable), .jabber_enable(jabber_enable),
	.serial_7wire_select(serial_7wire_select));

// >>> verification/pvs_mgmt_model.sv
// station management controller driving the management serial pins
`timescale 1ns/1ps
`include "pvs_consts.svh"
module pvs_mgmt_model (
	// device side
	input wire logic mdioOut,
	input wire logic mdioOe,
	// pins toward the device
	output logic     mdc,
	output logic     mdioIn
);
	logic mOe;
	logic mOut;

	// pulled up when nobody drives, so a silent device reads ones
	assign mdioIn = mdioOe ? mdioOut : (mOe ? mOut : 1'b1);
	initial begin
		mdc = 1'b0;
		mOe = 1'b0;
		mOut = 1'b1;
	end

	// one bit, changed while the clock is low
	task automatic sendBit(input logic b);
		mOe = 1'b1;
		mOut = b;
		#80 mdc = 1'b1;
		#80 mdc = 1'b0;
	endtask

	// whole frame; a read returns turnaround zero and the word
	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd, output logic [16:0] rd);
		logic [13:0] hdr;
		logic [17:0] wf;
		hdr = {2'b01, op, phy, ra};
		wf = {2'b10, wd};
		rd = 17'h1FFFF;
		#37;
		repeat (32) sendBit(1'b1);
		for (int i = 13; i >= 0; i--) sendBit(hdr[i]);
		if (op == `PVS_OP_WRITE) begin
			for (int i = 17; i >= 0; i--) sendBit(wf[i]);
		end else begin
			mOe = 1'b0;
			// first turnaround bit: nobody drives, not sampled
			#80 mdc = 1'b1;
			#80 mdc = 1'b0;
			// second turnaround bit and sixteen data bits, before each rise
			repeat (17) begin
				#80 rd = {rd[15:0], mdioIn};
				mdc = 1'b1;
				#80 mdc = 1'b0;
			end
		end
		mOe = 1'b0;
	endtask
endmodule

// >>> verification/pvs_regs_tb.sv
// self-checking bench for the vendor register bank
`timescale 1ns/1ps
`include "pvs_consts.svh"
module pvs_regs_tb;
	logic        clk, resetn, mdc, mdioIn, mdioOut, mdioOe, mgmt_irq_n;
	logic        linkUp, speed100, fullDuplex, loopback10;
	logic        polarity_reversed, rx_error_event, disconnectEvent;
	logic        link_pulse_enable, linkGoodForced, heartbeat_enable;
	logic        squelchNormal, jabber_enable, serial_7wire_select;
	logic [13:0] strapPins;
	logic [16:0] rd, e;
	logic [3:0]  m;
	logic [2:0]  t;
	int          failures, n_compared, n, ne;
	wire  [5:0]  ctl = {link_pulse_enable, linkGoodForced, heartbeat_enable,
		squelchNormal, jabber_enable, serial_7wire_select};

	pvs_regs dut (.clk(clk), .resetn(resetn), .mdc(mdc), .mdioIn(mdioIn),
		.mdioOut(mdioOut), .mdioOe(mdioOe), .mgmt_irq_n(mgmt_irq_n),
		.strapPins(strapPins), .linkUp(linkUp), .speed100(speed100),
		.fullDuplex(fullDuplex), .loopback10(loopback10),
		.polarity_reversed(polarity_reversed),
		.rx_error_event(rx_error_event), .disconnectEvent(disconnectEvent),
		.link_pulse_enable(link_pulse_enable),
		.linkGoodForced(linkGoodForced), .heartbeat_enable(heartbeat_enable),
		.squelchNormal(squelchNormal), .jabber_enable(jabber_enable),
		.serial_7wire_select(serial_7wire_select));
	pvs_mgmt_model mgr (.mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc),
		.mdioIn(mdioIn));

	always #5 clk = ~clk;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdReg(input logic [4:0] a, input logic [16:0] exp);
		mgr.frame(`PVS_OP_READ, strapPins[4:0], a, 16'h0000, rd);
		chk(rd, exp);
	endtask
	task automatic wrReg(input logic [4:0] a, input logic [15:0] d);
		mgr.frame(`PVS_OP_WRITE, strapPins[4:0], a, d, rd);
		repeat (3) @(posedge clk);
	endtask
	// expected interrupt word with turnaround zero on top
	function automatic logic [16:0] irqWord(input logic [3:0] mk,
		input logic [2:0] c);
		logic s;
		s = !mk[0] && |(c & ~mk[3:1]);
		return {1'b0, s, 3'b000, mk, 3'b000, c, 1'b0, s};
	endfunction
	function automatic logic [16:0] tenWord(input logic [4:0] cfg,
		input logic p);
		return {2'b00, cfg, 9'h000, p};
	endfunction
	task automatic doReset();
		@(posedge clk) #1 resetn = 1'b0;
		strapPins = 14'($urandom);
		repeat (6) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (8) @(posedge clk);
	endtask
	task automatic test_done();
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// watchdog, well past the expected run of some forty frames
	initial begin
		#800_000;
		failures++;
		test_done();
	end

	// main sequence
	initial begin
		void'($urandom(32'h1BC6B736));
		{clk, resetn, linkUp, speed100, fullDuplex, loopback10} = 6'h00;
		{rx_error_event, disconnectEvent, failures, n_compared} = '0;
		polarity_reversed = 1'($urandom);
		doReset();
		rdReg(`PVS_OFS_STRAP, {3'b000, strapPins});
		rdReg(`PVS_OFS_TENBASE, tenWord(5'h1E, polarity_reversed));
		chk(17'(ctl), 17'h0002E);
		#1 polarity_reversed = ~polarity_reversed;
		rdReg(`PVS_OFS_TENBASE, tenWord(5'h1E, polarity_reversed));
		rdReg(`PVS_OFS_IRQ, irqWord(4'hF, 3'b000));
		wrReg(`PVS_OFS_TENBASE, 16'hFFFF);
		rdReg(`PVS_OFS_TENBASE, tenWord(5'h1F, polarity_reversed));
		chk(17'(ctl), 17'h0002F);
		#1 speed100 = 1'b1;
		repeat (3) @(posedge clk);
		chk(17'(ctl), 17'h00006);
		wrReg(`PVS_OFS_TENBASE, 16'h0000);
		#1 {speed100, fullDuplex} = 2'b01;
		repeat (3) @(posedge clk);
		chk(17'(ctl), 17'h00010);
		wrReg(`PVS_OFS_TENBASE, 16'h6800);
		chk(17'(ctl), 17'h00022);
		#1 {fullDuplex, loopback10} = 2'b01;
		repeat (3) @(posedge clk);
		chk(17'(ctl), 17'h0002A);
		rdReg(`PVS_OFS_IRQ, irqWord(4'hF, 3'b110));
		rdReg(`PVS_OFS_IRQ, irqWord(4'hF, 3'b000));
		for (int i = 0; i < 8; i++) begin
			m = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : 4'($urandom);
			t = (i < 2) ? 3'b111 : 3'($urandom);
			e = irqWord(m, t);
			wrReg(`PVS_OFS_IRQ, {4'h0, m, 8'h00});
			#1 {fullDuplex, speed100, linkUp} = {fullDuplex, speed100, linkUp} ^ t;
			repeat (4) @(posedge clk);
			chk(17'(mgmt_irq_n), 17'(!e[15]));
			rdReg(`PVS_OFS_IRQ, e);
			repeat (4) @(posedge clk);
			chk(17'(mgmt_irq_n), 17'h00001);
		end
		n = $urandom_range(296, 256);
		ne = 0;
		for (int i = 0; i < n; i++) begin
			t = 3'($urandom);
			ne += t[0];
			@(posedge clk) #1 {rx_error_event, disconnectEvent} = {t[0], 1'b1};
			@(posedge clk) #1 {rx_error_event, disconnectEvent} = 2'b00;
		end
		rdReg(`PVS_OFS_RXERR, {1'b0, 16'(ne)});
		rdReg(`PVS_OFS_DISC, {9'h000, 8'(n)});
		rdReg(`PVS_OFS_DISC, {9'h000, 8'(n)});
		rdReg(5'h13, 17'h00000);
		mgr.frame(`PVS_OP_WRITE, ~strapPins[4:0], `PVS_OFS_TENBASE, 16'h0, rd);
		rdReg(`PVS_OFS_TENBASE, tenWord(5'h1A, polarity_reversed));
		mgr.frame(`PVS_OP_READ, ~strapPins[4:0], `PVS_OFS_STRAP, 16'h0, rd);
		chk(rd, 17'h1FFFF);
		doReset();
		rdReg(`PVS_OFS_STRAP, {3'b000, strapPins});
		rdReg(`PVS_OFS_TENBASE, tenWord(5'h1E, polarity_reversed));
		rdReg(`PVS_OFS_RXERR, 17'h00000);
		rdReg(`PVS_OFS_IRQ, irqWord(4'hF, 3'b000));
		test_done();
	end
endmodule
